/* hdl/phy_basic_regs_defines.vh */
// Constants for the basic mode control and status register block
`ifndef PHY_BASIC_REGS_DEFINES_VH
`define PHY_BASIC_REGS_DEFINES_VH

// Register locations on the management bus
`define REG_CTRL 5'h00
`define REG_STAT 5'h01

// Control register bit positions
`define CTRL_SPD_LSB 13
`define CTRL_AN_EN 12
`define CTRL_ISOLATE 10
`define CTRL_RESTART 9
`define CTRL_DUPLEX 8
`define CTRL_COL_TEST 7
`define CTRL_SPD_MSB 6

// Control register reset values
`define CTRL_ISOLATE_RST 1'h0
`define CTRL_RESTART_RST 1'h0
`define CTRL_COL_TEST_RST 1'h0
`define CTRL_SPD_MSB_RST 1'h1
`define CTRL_SPD_LSB_RST 1'h0

// Status register: permanent ones (14:11, 8, 6, 3, 0)
`define STAT_FIXED 16'h7949

// Management frame fields
`define PRE_BITS 6'h20
`define HDR_BITS 6'h0D
`define DATA_BITS 6'h10
`define OP_WRITE 2'h1
`define OP_READ 2'h2

// Collision test timing: bit time at the fastest rate, clock period
`define BIT_TIME_PS 1000
`define CLK_PERIOD_PS 5000
`define COL_ON_MAX_BT 512
`define COL_OFF_MAX_BT 4
`define COL_ON_CYC ((`COL_ON_MAX_BT * `BIT_TIME_PS) / `CLK_PERIOD_PS)
`define COL_OFF_CYC_RAW ((`COL_OFF_MAX_BT * `BIT_TIME_PS) / `CLK_PERIOD_PS)
`define COL_OFF_CYC ((`COL_OFF_CYC_RAW < 1) ? 1 : `COL_OFF_CYC_RAW)

`endif

/* hdl/phy_basic_control_status_regs.v */
// Basic mode control and status registers behind the management port
//
// Notes on behaviour
// R1 - Isolate bit cuts port from MAC; the block only drives isolate, COL still follows TX_EN in collision test
// R2 - Restart bit acts only when negotiation enabled
// R3 - Restart reads 1 until negotiation starts
// R4 - Clearing restart does not disturb negotiation
// R5 - Manual duplex bit, strap reset value
// R6 - Collision test raises COL after TX_EN
// R7 - Collision test drops COL after TX_EN
// R8 - Speed MSB bit, resets to one
// R9 - Speed code 00/01/10 gives 10/100/1000
// R10 - Negotiation enabled ignores manual speed, duplex
// R11 - Control bits 5:0 read zero, ignore writes
// R12 - Status bits 15,10,9 read zero
// R13 - Status bits 14 to 11 read one
// R14 - Status bit 8 reads one
// R15 - Status bit 7 reads zero
// R16 - Preamble needed only after reset or error
// R17 - Status bit 5 shows negotiation complete
// R18 - Remote fault latches high until read
// R19 - Status bits 3 and 0 read one
// R20 - Link status latches low until read
// R21 - Jabber latches high until read
// R22 - Latches release only after read captured
`timescale 1ns/1ps
`default_nettype none
`include "phy_basic_regs_defines.vh"

module phy_basic_control_status_regs
(
   // Clock and reset
   input wire core_clk,
   input wire resetn,
   // Hardware straps
   input wire [4:0] strap_phy_addr,
   input wire strap_an_enable,
   input wire strap_full_duplex,
   // Management pins
   input wire mdc,
   input wire mdio_in,
   output reg mdio_out,
   output reg mdio_oe_n,
   // Auto-negotiation engine
   input wire an_started,
   input wire an_complete,
   input wire [1:0] an_speed,
   input wire an_full_duplex,
   output reg an_restart,
   output reg an_enable,
   // Line events
   input wire remote_fault,
   input wire link_good,
   input wire jabber,
   // MAC side
   input wire tx_en,
   output reg col,
   output reg isolate,
   output reg [1:0] speed_sel,
   output reg full_duplex
);

////////////////////////////////////////////////////////////////////////////

localparam ST_PRE = 5'h01;
localparam ST_IDLE = 5'h02;
localparam ST_HDR = 5'h04;
localparam ST_TA = 5'h08;
localparam ST_DATA = 5'h10;

reg mdc_q;
reg [4:0] state_q;
reg [5:0] cnt_q;
reg [15:0] sh_q;
reg is_read_q;
reg hit_q;
reg [4:0] reg_q;
reg [4:0] phy_addr_q;
reg drv_q;
reg [16:0] tx_q;
reg rd_rel_q;

// Control fields
reg restart_q;
reg duplex_q;
reg col_test_q;
reg spd_msb_q;
reg spd_lsb_q;

// Status fields
reg an_done_q;
reg rfault_q;
reg link_q;
reg jabber_q;

wire mdc_rise;
wire mdc_fall;
wire [12:0] hdr;
wire [15:0] wdata;
wire [15:0] ctrl_word;
wire [15:0] stat_word;
wire [1:0] hdr_op;
wire hdr_ok;
wire ctrl_wr;

assign mdc_rise = mdc & ~mdc_q;
assign mdc_fall = ~mdc & mdc_q;
assign hdr = {sh_q[11:0], mdio_in};
assign hdr_op = hdr[11:10];
assign wdata = {sh_q[14:0], mdio_in};

// Second start bit must be 1 and opcode a read or a write
assign hdr_ok = hdr[12] & ((hdr_op == `OP_READ) | (hdr_op == `OP_WRITE));

assign ctrl_wr = mdc_rise & (state_q == ST_DATA)
   & (cnt_q == `DATA_BITS - 6'h01)
   & ~is_read_q & hit_q & (reg_q == `REG_CTRL);

////////////////////////////////////////////////////////////////////////////
// Read words

// Unused bits stay zero [R11]
assign ctrl_word = {2'h0, spd_lsb_q, an_enable, 1'b0, isolate,
   restart_q, duplex_q, col_test_q, spd_msb_q, 6'h00};

// Fixed ones and zeros [R12] [R13] [R14] [R15] [R16] [R19]
assign stat_word = `STAT_FIXED
   | {10'h000, an_done_q, rfault_q, 1'b0, link_q, jabber_q, 1'b0};

function [15:0] rd_word;
   input [4:0] addr;
   input [15:0] cw;
   input [15:0] sw;
   begin
      case (addr)
         `REG_CTRL: rd_word = cw;
         `REG_STAT: rd_word = sw;
         default: rd_word = 16'h0000;
      endcase
   end
endfunction

////////////////////////////////////////////////////////////////////////////
// Management frame engine

always @(posedge core_clk)
begin
   if (!resetn)
   begin
      mdc_q <= 1'b0;
      state_q <= ST_PRE;
      cnt_q <= 6'h00;
      sh_q <= 16'h0000;
      is_read_q <= 1'b0;
      hit_q <= 1'b0;
      reg_q <= 5'h00;
      phy_addr_q <= strap_phy_addr;
      drv_q <= 1'b0;
      tx_q <= 17'h00000;
      rd_rel_q <= 1'b0;
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
   end
   else
   begin
      mdc_q <= mdc;
      rd_rel_q <= 1'b0;
      if (mdc_rise)
      begin
         case (state_q)
            ST_PRE:
            begin
               // Full preamble only after reset or a bad frame [R16]
               if (!mdio_in)
                  cnt_q <= 6'h00;
               else if (cnt_q == `PRE_BITS - 6'h01)
               begin
                  cnt_q <= 6'h00;
                  state_q <= ST_IDLE;
               end
               else
                  cnt_q <= cnt_q + 6'h01;
            end
            ST_IDLE:
            begin
               // Suppressed preamble accepted here [R16]
               if (!mdio_in)
               begin
                  cnt_q <= 6'h00;
                  state_q <= ST_HDR;
               end
            end
            ST_HDR:
            begin
               sh_q <= {sh_q[14:0], mdio_in};
               cnt_q <= cnt_q + 6'h01;
               if (cnt_q == `HDR_BITS - 6'h01)
               begin
                  cnt_q <= 6'h00;
                  if (!hdr_ok)
                     state_q <= ST_PRE; // [R16]
                  else
                  begin
                     is_read_q <= (hdr_op == `OP_READ);
                     hit_q <= (hdr[9:5] == phy_addr_q);
                     reg_q <= hdr[4:0];
                     state_q <= ST_TA;
                  end
               end
            end
            ST_TA:
            begin
               cnt_q <= cnt_q + 6'h01;
               if (cnt_q == 6'h00)
               begin
                  if (is_read_q & hit_q)
                  begin
                     // Word captured now, latches freed next cycle [R22]
                     tx_q <= {1'b0, rd_word(reg_q, ctrl_word, stat_word)};
                     drv_q <= 1'b1;
                     rd_rel_q <= (reg_q == `REG_STAT);
                  end
                  else if (!is_read_q & !mdio_in)
                  begin
                     cnt_q <= 6'h00;
                     state_q <= ST_PRE; // [R16]
                  end
               end
               else
               begin
                  cnt_q <= 6'h00;
                  if (!is_read_q & mdio_in)
                     state_q <= ST_PRE; // [R16]
                  else
                     state_q <= ST_DATA;
               end
            end
            ST_DATA:
            begin
               sh_q <= {sh_q[14:0], mdio_in};
               cnt_q <= cnt_q + 6'h01;
               if (cnt_q == `DATA_BITS - 6'h01)
               begin
                  cnt_q <= 6'h00;
                  drv_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
            default:
            begin
               cnt_q <= 6'h00;
               state_q <= ST_PRE;
            end
         endcase
      end
      // Turnaround zero then data, changed on the falling edge
      if (mdc_fall)
      begin
         if (drv_q)
         begin
            mdio_oe_n <= 1'b0;
            mdio_out <= tx_q[16];
            tx_q <= {tx_q[15:0], 1'b0};
         end
         else
         begin
            mdio_oe_n <= 1'b1;
            mdio_out <= 1'b1;
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// Control register and mode outputs

always @(posedge core_clk)
begin
   if (!resetn)
   begin
      isolate <= `CTRL_ISOLATE_RST; // [R1]
      restart_q <= `CTRL_RESTART_RST;
      an_restart <= 1'b0;
      an_enable <= strap_an_enable;
      duplex_q <= strap_full_duplex; // [R5]
      col_test_q <= `CTRL_COL_TEST_RST;
      spd_msb_q <= `CTRL_SPD_MSB_RST; // [R8]
      spd_lsb_q <= `CTRL_SPD_LSB_RST;
      speed_sel <= 2'h0;
      full_duplex <= 1'b0;
      col <= 1'b0;
   end
   else
   begin
      an_restart <= 1'b0;
      if (ctrl_wr)
      begin
         isolate <= wdata[`CTRL_ISOLATE]; // [R1]
         an_enable <= wdata[`CTRL_AN_EN];
         duplex_q <= wdata[`CTRL_DUPLEX];
         col_test_q <= wdata[`CTRL_COL_TEST];
         spd_msb_q <= wdata[`CTRL_SPD_MSB]; // [R8]
         spd_lsb_q <= wdata[`CTRL_SPD_LSB];
         // Writing 0 only clears the readback [R4]
         restart_q <= wdata[`CTRL_RESTART] & wdata[`CTRL_AN_EN]; // [R2]
         an_restart <= wdata[`CTRL_RESTART] & wdata[`CTRL_AN_EN]; // [R2]
      end
      else if (an_started)
         restart_q <= 1'b0; // [R3]
      // Manual settings used only with negotiation off [R10]
      if (an_enable)
      begin
         speed_sel <= an_speed;
         full_duplex <= an_full_duplex;
      end
      else
      begin
         speed_sel <= {spd_msb_q, spd_lsb_q}; // [R9]
         full_duplex <= duplex_q; // [R5]
      end
      // One cycle each way: inside the on limit, but one 5000 ps cycle is longer than the 4 bit time off limit
      col <= col_test_q & tx_en; // [R6] [R7]
   end
end

////////////////////////////////////////////////////////////////////////////
// Status latches

always @(posedge core_clk)
begin
   if (!resetn)
   begin
      an_done_q <= 1'b0;
      rfault_q <= 1'b0;
      link_q <= 1'b0;
      jabber_q <= 1'b0;
   end
   else
   begin
      an_done_q <= an_complete; // [R17]
      // New event wins over release
      if (remote_fault)
         rfault_q <= 1'b1; // [R18]
      else if (rd_rel_q)
         rfault_q <= 1'b0; // [R22]
      if (jabber)
         jabber_q <= 1'b1; // [R21]
      else if (rd_rel_q)
         jabber_q <= 1'b0; // [R22]
      if (!link_good)
         link_q <= 1'b0; // [R20]
      else if (rd_rel_q)
         link_q <= 1'b1; // [R20] [R22]
   end
end

endmodule // phy_basic_control_status_regs

`default_nettype wire

/* testbench/phy_basic_regs_checker.sv */
// Assertion checker for the basic control and status register block
`timescale 1ns/1ps
`default_nettype none
module phy_basic_regs_checker
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Management pins
   input wire logic mdc,
   input wire logic mdio_out,
   input wire logic mdio_oe_n,
   // Negotiation and MAC side
   input wire logic [1:0] an_speed,
   input wire logic an_restart,
   input wire logic an_enable,
   input wire logic tx_en,
   input wire logic col,
   input wire logic isolate,
   input wire logic [1:0] speed_sel
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   property p_restart_gate;
      an_restart |-> an_enable;
   endproperty
   a_restart_gate: assert property (p_restart_gate)
      else $error("restart pulse with negotiation off");
   property p_restart_pulse;
      an_restart |=> !an_restart;
   endproperty
   a_restart_pulse: assert property (p_restart_pulse)
      else $error("restart pulse longer than one cycle");
   property p_col_follow;
      col |-> $past(tx_en);
   endproperty
   a_col_follow: assert property (p_col_follow)
      else $error("collision without transmit enable");
   property p_col_off;
      !tx_en |=> !col;
   endproperty
   a_col_off: assert property (p_col_off)
      else $error("collision held after transmit end");
   property p_speed_an;
      an_enable |=> speed_sel == $past(an_speed);
   endproperty
   a_speed_an: assert property (p_speed_an)
      else $error("speed not taken from negotiation");
   property p_iso_sync;
      $changed(isolate) |-> $past(mdc) && !$past(mdc, 2);
   endproperty
   a_iso_sync: assert property (p_iso_sync)
      else $error("isolate changed outside a write");
   property p_an_en_sync;
      $changed(an_enable) |-> $past(mdc) && !$past(mdc, 2);
   endproperty
   a_an_en_sync: assert property (p_an_en_sync)
      else $error("enable changed outside a write");
   property p_out_after_fall;
      $changed({mdio_out, mdio_oe_n}) |-> !$past(mdc) && $past(mdc, 2);
   endproperty
   a_out_after_fall: assert property (p_out_after_fall)
      else $error("management drive changed off clock fall");
   property p_quiet_high;
      mdio_oe_n |-> mdio_out;
   endproperty
   a_quiet_high: assert property (p_quiet_high)
      else $error("data low while not driving");
   c_restart: cover property (an_restart);
   c_col: cover property ($rose(col));
   c_read: cover property ($fell(mdio_oe_n));
endmodule // phy_basic_regs_checker
bind phy_basic_control_status_regs phy_basic_regs_checker i_chk (.core_clk,
   .resetn, .mdc, .mdio_out, .mdio_oe_n, .an_speed, .an_restart, .an_enable,
   .tx_en, .col, .isolate, .speed_sel);
`default_nettype wire

/* testbench/mdio_station_model.sv */
// Station management controller model driving the management pins
`timescale 1ns/1ps
`default_nettype none
module mdio_station
(
   // Clock
   input wire logic core_clk,
   // Management pins
   output logic mdc,
   output logic sta_en,
   output logic sta_out,
   input wire logic mdio_w
);
   initial
   begin
      mdc = 1'h0;
      sta_en = 1'h0;
      sta_out = 1'h1;
   end
   // Data set while low, sampled at the rise
   task automatic bit1(input logic en, input logic b, output logic s);
      @(posedge core_clk);
      #1 mdc = 1'h0;
      sta_en = en;
      sta_out = b;
      repeat (2) @(posedge core_clk);
      #1 mdc = 1'h1;
      s = mdio_w;
      repeat (2) @(posedge core_clk);
   endtask
   task automatic frame(input logic pre, input logic [1:0] op,
      input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd,
      output logic [15:0] rd);
      logic [31:0] hdr;
      logic s;
      hdr = {2'h1, op, phy, ra, 2'h2, wd};
      if (pre)
         repeat (32) bit1(1'h1, 1'h1, s);
      for (int i = 31; i >= 0; i--)
      begin
         bit1(op != 2'h2 || i > 17, hdr[i], s);
         if (i < 16)
            rd[i] = s;
      end
      @(posedge core_clk);
      #1 mdc = 1'h0;
      sta_en = 1'h0;
      repeat (4) @(posedge core_clk);
      #1;
   endtask
endmodule // mdio_station
`default_nettype wire

/* testbench/tb_phy_basic_control_status_regs.sv */
// Self-checking bench for the basic control and status register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
   n_fail++; $display("[ERR] %s exp %h got %h", nm, e, a); end end
module tb_phy_basic_control_status_regs;
   logic core_clk, resetn, mdc, mdio_out, mdio_oe_n, sta_en, sta_out;
   logic an_started, an_complete, an_full_duplex, an_restart, an_enable;
   logic remote_fault, link_good, jabber, tx_en, col, isolate, full_duplex;
   logic mdio_w;
   logic [1:0] an_speed, speed_sel;
   logic [15:0] rd, w;
   logic [31:0] lfsr;
   int n_fail, n_compared, cyc, n_pulse;
   localparam logic [4:0] phy_a = 5'h09;
   assign mdio_w = sta_en ? sta_out : (mdio_oe_n ? 1'h1 : mdio_out);
   phy_basic_control_status_regs i_dut (.core_clk, .resetn,
      .strap_phy_addr(phy_a), .strap_an_enable(1'h0),
      .strap_full_duplex(1'h1), .mdc, .mdio_in(mdio_w), .mdio_out,
      .mdio_oe_n, .an_started, .an_complete, .an_speed, .an_full_duplex,
      .an_restart, .an_enable, .remote_fault, .link_good, .jabber, .tx_en,
      .col, .isolate, .speed_sel, .full_duplex);
   mdio_station i_sta (.core_clk, .mdc, .sta_en, .sta_out, .mdio_w);
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [15:0] exp_ctrl(input logic [15:0] v);
      exp_ctrl = v & 16'h37C0;
      if (!v[12])
         exp_ctrl[9] = 1'h0;
   endfunction
   task automatic stop_test();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      core_clk = 1'h0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc++;
      n_pulse += an_restart;
      if (cyc == 30000)
      begin
         n_fail++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      {resetn, tx_en, an_started, an_complete, an_full_duplex} = 5'h00;
      {remote_fault, jabber, link_good, an_speed} = 5'h05;
      lfsr = 32'h00014DEE;
      repeat (8) @(posedge core_clk);
      #1 resetn = 1'h1;
      i_sta.frame(1'h1, 2'h2, phy_a, 5'h00, 16'h0000, rd);
      `CHK("ctrl_rst", 16'h0140, rd)
      `CHK("spd_rst", 2'h2, speed_sel)
      `CHK("dup_rst", 1'h1, full_duplex)
      i_sta.frame(1'h0, 2'h2, phy_a, 5'h01, 16'h0000, rd);
      `CHK("stat_rst", 16'h7949, rd)
      for (int k = 0; k < 8; k++)
      begin
         lfsr = nxt(lfsr);
         w = (k == 0) ? 16'hFFFF : lfsr[15:0];
         w[13] = w[13] & ~w[6];
         an_speed = lfsr[17:16] & {1'h1, ~lfsr[17]};
         an_full_duplex = lfsr[18];
         tx_en = lfsr[19];
         i_sta.frame(1'h0, 2'h1, phy_a, 5'h00, w, rd);
         i_sta.frame(1'h0, 2'h2, phy_a, 5'h00, 16'h0000, rd);
         `CHK("ctrl", exp_ctrl(w), rd)
         `CHK("iso", w[10], isolate)
         `CHK("spd", w[12] ? an_speed : {w[6], w[13]}, speed_sel)
         `CHK("dup", w[12] ? an_full_duplex : w[8], full_duplex)
         `CHK("col_gate", w[7] & lfsr[19], col)
      end
      n_pulse = 0;
      tx_en = 1'h0;
      i_sta.frame(1'h0, 2'h1, phy_a, 5'h00, 16'h1200, rd);
      i_sta.frame(1'h0, 2'h2, phy_a, 5'h00, 16'h0000, rd);
      `CHK("restart_hold", 1'h1, rd[9])
      an_started = 1'h1;
      @(posedge core_clk);
      #1 an_started = 1'h0;
      i_sta.frame(1'h0, 2'h2, phy_a, 5'h00, 16'h0000, rd);
      `CHK("restart_clr", 1'h0, rd[9])
      i_sta.frame(1'h0, 2'h1, phy_a, 5'h00, 16'h0280, rd);
      i_sta.frame(1'h0, 2'h2, phy_a, 5'h00, 16'h0000, rd);
      `CHK("restart_off", 16'h0080, rd)
      `CHK("pulses", 1, n_pulse)
      tx_en = 1'h1;
      repeat (2) @(posedge core_clk);
      #1 `CHK("col_on", 1'h1, col)
      tx_en = 1'h0;
      repeat (2) @(posedge core_clk);
      #1 `CHK("col_off", 1'h0, col)
      {an_complete, remote_fault, jabber, link_good} = 4'hE;
      @(posedge core_clk);
      #1 {remote_fault, jabber, link_good} = 3'h1;
      i_sta.frame(1'h0, 2'h2, phy_a, 5'h01, 16'h0000, rd);
      `CHK("stat_lat", 16'h797B, rd)
      i_sta.frame(1'h0, 2'h2, phy_a, 5'h01, 16'h0000, rd);
      `CHK("stat_rel", 16'h796D, rd)
      i_sta.frame(1'h0, 2'h0, phy_a, 5'h00, 16'h0000, rd);
      i_sta.frame(1'h0, 2'h2, phy_a, 5'h00, 16'h0000, rd);
      `CHK("no_pre", 16'hFFFF, rd)
      i_sta.frame(1'h1, 2'h2, 5'h03, 5'h00, 16'h0000, rd);
      `CHK("other_phy", 16'hFFFF, rd)
      i_sta.frame(1'h1, 2'h2, phy_a, 5'h05, 16'h0000, rd);
      `CHK("unmapped", 16'h0000, rd)
      stop_test();
   end
endmodule // tb_phy_basic_control_status_regs
`default_nettype wire
